// >>> verilog/sps_pkg.sv
// package for the step pattern sequencer: register map, field widths, timing counts
package sps_pkg;

    // ==========================================================
    // register map (byte addresses on the axi4-lite slave)
    localparam logic [7:0] SPS_ADDR_TICK = 8'h00;
    localparam logic [7:0] SPS_ADDR_TIMER = 8'h04;
    localparam logic [7:0] SPS_ADDR_PRESET = 8'h08;
    localparam logic [7:0] SPS_ADDR_CURRENT = 8'h0C;
    localparam logic [7:0] SPS_ADDR_CTRL = 8'h10;
    localparam logic [7:0] SPS_ADDR_STATUS = 8'h14;
    localparam logic [7:0] SPS_ADDR_TBASE = 8'h18;
    localparam logic [7:0] SPS_ADDR_LAST = 8'h1C;
    localparam logic [7:0] SPS_ADDR_COUNTS = 8'h40;
    localparam logic [7:0] SPS_ADDR_PATTERN = 8'h80;
    localparam logic [7:0] SPS_ADDR_EVSEL = 8'hC0;

    // ==========================================================
    // control and status register fields
    localparam int SPS_CTRL_RUN_BIT = 0;
    localparam int SPS_CTRL_MODE_BIT = 1;
    localparam int SPS_STAT_DONE_BIT = 0;
    localparam int SPS_STAT_RUN_BIT = 1;

    // ==========================================================
    // sizes and reset values
    localparam int SPS_STEPS = 16;
    localparam logic [4:0] SPS_STEP_MIN = 5'h01;
    localparam logic [4:0] SPS_STEP_MAX = 5'h10;
    localparam logic [15:0] SPS_COUNTS_MAX = 16'h270F;
    localparam logic [15:0] SPS_TBASE_MAX = 16'h270F;
    localparam logic [15:0] SPS_TBASE_RESET = 16'h000A;
    localparam logic [4:0] SPS_PRESET_RESET = 5'h01;
    localparam logic [4:0] SPS_EV_NONE = 5'h00;
    localparam logic [1:0] SPS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPS_RESP_SLVERR = 2'h2;

    // ==========================================================
    // timing: one timer value unit is a hundredth of a second
    localparam int SPS_CLK_HZ = 25000000;
    localparam int SPS_HUNDREDTH_US = 10000;
    localparam int SPS_HUNDREDTH_CYC = SPS_CLK_HZ / 1000000 * SPS_HUNDREDTH_US;

    // sequencer modes
    typedef enum logic [1:0] {
        SPS_MODE_TIMED = 2'b01,
        SPS_MODE_EVENT = 2'b10
    } sps_mode_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        SPS_ST_IDLE = 3'b001,
        SPS_ST_STEP = 3'b010,
        SPS_ST_DONE = 3'b100
    } sps_state_t;

    // control inputs from the controlling program, travel together
    typedef struct packed {
        logic start;
        logic jog;
        logic reset;
    } sps_ctl_t;

endpackage : sps_pkg

// >>> verilog/sps_sequencer.sv
// step pattern sequencer with axi4-lite register access
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sps_sequencer
    import sps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] ctl_in,
    input wire logic [15:0] event_in,
    input wire logic scan_tick,
    output logic [15:0] step_outputs,
    output logic sequence_done_flag,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ==========================================================
    // helper functions
    // clamp a preset write into the legal step range
    function automatic logic [4:0] clamp_step(input logic [15:0] v);
        if (v < 16'(SPS_STEP_MIN)) begin
            clamp_step = SPS_STEP_MIN;
        end else if (v > 16'(SPS_STEP_MAX)) begin
            clamp_step = SPS_STEP_MAX;
        end else begin
            clamp_step = v[4:0];
        end
    endfunction : clamp_step

    // clamp a count field to its four-digit ceiling
    function automatic logic [15:0] clamp_cnt(input logic [15:0] v);
        clamp_cnt = (v > SPS_COUNTS_MAX) ? SPS_COUNTS_MAX : v;
    endfunction : clamp_cnt

    // ==========================================================
    // configuration and status storage
    sps_state_t state_reg;
    sps_ctl_t ctl_s1_reg;
    sps_ctl_t ctl_reg;
    logic [15:0] ev_s1_reg;
    logic [15:0] ev_reg;
    logic scan_s1_reg;
    logic scan_reg;
    logic jog_prev_reg;
    logic run_reg;
    logic run_prev_reg;
    logic mode_event_reg;
    logic [15:0] tbase_reg;
    logic [4:0] last_step_reg;
    logic [4:0] preset_reg;
    logic [4:0] cur_reg;
    logic [15:0] tick_reg;
    logic [15:0] tval_reg;
    logic [31:0] hund_reg;
    logic [15:0] counts_mem [SPS_STEPS];
    logic [15:0] pattern_mem [SPS_STEPS];
    logic [4:0] evsel_mem [SPS_STEPS];

    // ==========================================================
    // input synchronisers: controls and events come from another domain
    always_ff @(posedge ref_clk) begin
        ctl_s1_reg <= ctl_in;
        ctl_reg <= ctl_s1_reg;
        ev_s1_reg <= event_in;
        ev_reg <= ev_s1_reg;
        scan_s1_reg <= scan_tick;
        scan_reg <= scan_s1_reg;
    end

    // ==========================================================
    // step decode
    logic [3:0] idx;
    logic [15:0] step_counts;
    logic [4:0] step_ev;
    logic ev_true;
    logic jog_edge;
    logic run_entry;
    logic hund_hit;
    logic count_hit;
    logic base_zero;
    assign idx = 4'(cur_reg - 5'h01);
    assign step_counts = counts_mem[idx];
    assign step_ev = evsel_mem[idx];
    // unassigned event reads as true, so the step runs on time alone
    assign ev_true = (step_ev == SPS_EV_NONE) || !mode_event_reg || ev_reg[4'(step_ev - 5'h01)];
    assign jog_edge = mode_event_reg && ctl_reg.jog && !jog_prev_reg;
    assign run_entry = run_reg && !run_prev_reg;
    assign base_zero = (tbase_reg == 16'h0000);
    assign hund_hit = (hund_reg >= 32'(SPS_HUNDREDTH_CYC - 1));
    // zero counts: the step passes in each cycle that the synchronised scan input is high, one step per such cycle
    assign count_hit = (step_counts == 16'h0000) ? scan_reg : (tick_reg >= step_counts);

    // ==========================================================
    // sequencer state machine and counters
    logic running;
    logic advance;
    logic at_last;
    assign running = (state_reg == SPS_ST_STEP) && ctl_reg.start && !ctl_reg.reset && ev_true;
    assign at_last = (cur_reg >= last_step_reg);
    always_comb begin
        advance = 1'b0;
        if (state_reg == SPS_ST_STEP && !ctl_reg.reset) begin
            if (jog_edge) begin
                advance = 1'b1;
            end else if (running && count_hit) begin
                advance = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= SPS_ST_IDLE;
            cur_reg <= SPS_PRESET_RESET;
            tick_reg <= 16'h0000;
            tval_reg <= 16'h0000;
            hund_reg <= 32'h0000_0000;
            jog_prev_reg <= 1'b0;
            run_prev_reg <= 1'b0;
            sequence_done_flag <= 1'b0;
        end else begin
            jog_prev_reg <= ctl_reg.jog;
            run_prev_reg <= run_reg;
            case (state_reg)
                SPS_ST_IDLE: begin
                    if (run_entry) begin
                        cur_reg <= preset_reg;
                        tick_reg <= 16'h0000;
                        tval_reg <= 16'h0000;
                        hund_reg <= 32'h0000_0000;
                        sequence_done_flag <= 1'b0;
                        state_reg <= SPS_ST_STEP;
                    end
                end
                SPS_ST_STEP, SPS_ST_DONE: begin
                    if (!run_reg) begin
                        state_reg <= SPS_ST_IDLE;
                    end else if (ctl_reg.reset) begin
                        cur_reg <= preset_reg;
                        sequence_done_flag <= 1'b0;
                        tick_reg <= 16'h0000;
                        tval_reg <= 16'h0000;
                        hund_reg <= 32'h0000_0000;
                        state_reg <= SPS_ST_STEP;
                    end else if (state_reg == SPS_ST_DONE) begin
                        state_reg <= SPS_ST_DONE;
                    end else if (advance) begin
                        tick_reg <= 16'h0000;
                        tval_reg <= 16'h0000;
                        hund_reg <= 32'h0000_0000;
                        if (at_last) begin
                            sequence_done_flag <= 1'b1;
                            state_reg <= SPS_ST_DONE;
                        end else begin
                            cur_reg <= cur_reg + 5'h01;
                        end
                    end else if (running && !base_zero && step_counts != 16'h0000) begin
                        // hundredths divider, then timer base, then counts
                        if (hund_hit) begin
                            hund_reg <= 32'h0000_0000;
                            if (tval_reg + 16'h0001 >= tbase_reg) begin
                                tval_reg <= 16'h0000;
                                tick_reg <= tick_reg + 16'h0001;
                            end else begin
                                tval_reg <= tval_reg + 16'h0001;
                            end
                        end else begin
                            hund_reg <= hund_reg + 32'h0000_0001;
                        end
                    end
                    // start low: only jog and reset act; the timer and counts are frozen
                end
                default: begin
                    state_reg <= SPS_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // pattern outputs, live whenever run mode is on
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            step_outputs <= 16'h0000;
        end else if (run_reg && state_reg != SPS_ST_IDLE) begin
            step_outputs <= pattern_mem[idx];
        end else begin
            step_outputs <= 16'h0000;
        end
    end

    // ==========================================================
    // axi4-lite write channel: address and data taken in either order
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_go;
    assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SPS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok(aw_addr_reg) ? SPS_RESP_OKAY : SPS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable addresses; monitoring counters refuse writes
    function automatic logic wr_ok(input logic [7:0] a);
        if (a == SPS_ADDR_PRESET || a == SPS_ADDR_CTRL || a == SPS_ADDR_TBASE || a == SPS_ADDR_LAST) begin
            wr_ok = 1'b1;
        end else if (a >= SPS_ADDR_COUNTS && a[1:0] == 2'b00) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    endfunction : wr_ok

    // merged write word, low half only is meaningful
    logic [15:0] wv;
    assign wv = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00, w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};

    // register writes; the preset may change at any time
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            preset_reg <= SPS_PRESET_RESET;
            run_reg <= 1'b0;
            mode_event_reg <= 1'b1;
            tbase_reg <= SPS_TBASE_RESET;
            last_step_reg <= SPS_STEP_MAX;
            for (int i = 0; i < SPS_STEPS; i++) begin
                counts_mem[i] <= 16'h0000;
                pattern_mem[i] <= 16'h0000;
                evsel_mem[i] <= SPS_EV_NONE;
            end
        end else if (wr_go && w_strb_reg[1:0] != 2'b00) begin
            if (aw_addr_reg == SPS_ADDR_PRESET) begin
                preset_reg <= clamp_step(wv);
            end else if (aw_addr_reg == SPS_ADDR_CTRL) begin
                run_reg <= wv[SPS_CTRL_RUN_BIT];
                mode_event_reg <= wv[SPS_CTRL_MODE_BIT];
            end else if (aw_addr_reg == SPS_ADDR_TBASE) begin
                tbase_reg <= (wv > SPS_TBASE_MAX) ? SPS_TBASE_MAX : wv;
            end else if (aw_addr_reg == SPS_ADDR_LAST) begin
                last_step_reg <= clamp_step(wv);
            end else if (aw_addr_reg >= SPS_ADDR_EVSEL) begin
                evsel_mem[aw_addr_reg[5:2]] <= (wv > 16'(SPS_STEP_MAX)) ? SPS_EV_NONE : wv[4:0];
            end else if (aw_addr_reg >= SPS_ADDR_PATTERN) begin
                pattern_mem[aw_addr_reg[5:2]] <= wv;
            end else if (aw_addr_reg >= SPS_ADDR_COUNTS && aw_addr_reg[1:0] == 2'b00) begin
                counts_mem[aw_addr_reg[5:2]] <= clamp_cnt(wv);
            end
        end
    end

    // ==========================================================
    // axi4-lite read channel, one cycle after the address is taken
    logic [31:0] rd_word;
    logic rd_ok;
    // a refused read must return zero data, not whatever the decode picked
    assign rd_ok = s_axi_araddr[1:0] == 2'b00 && (s_axi_araddr <= SPS_ADDR_LAST || s_axi_araddr >= SPS_ADDR_COUNTS);
    always_comb begin
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == SPS_ADDR_TICK) begin
            rd_word = {16'h0000, tick_reg};
        end else if (s_axi_araddr == SPS_ADDR_TIMER) begin
            rd_word = {16'h0000, tval_reg};
        end else if (s_axi_araddr == SPS_ADDR_PRESET) begin
            rd_word = {27'h0, preset_reg};
        end else if (s_axi_araddr == SPS_ADDR_CURRENT) begin
            rd_word = {27'h0, cur_reg};
        end else if (s_axi_araddr == SPS_ADDR_CTRL) begin
            rd_word = {30'h0, mode_event_reg, run_reg};
        end else if (s_axi_araddr == SPS_ADDR_STATUS) begin
            rd_word = {30'h0, state_reg != SPS_ST_IDLE, sequence_done_flag};
        end else if (s_axi_araddr == SPS_ADDR_TBASE) begin
            rd_word = {16'h0000, tbase_reg};
        end else if (s_axi_araddr == SPS_ADDR_LAST) begin
            rd_word = {27'h0, last_step_reg};
        end else if (s_axi_araddr >= SPS_ADDR_EVSEL) begin
            rd_word = {27'h0, evsel_mem[s_axi_araddr[5:2]]};
        end else if (s_axi_araddr >= SPS_ADDR_PATTERN) begin
            rd_word = {16'h0000, pattern_mem[s_axi_araddr[5:2]]};
        end else if (s_axi_araddr >= SPS_ADDR_COUNTS) begin
            rd_word = {16'h0000, counts_mem[s_axi_araddr[5:2]]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SPS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
                s_axi_rresp <= rd_ok ? SPS_RESP_OKAY : SPS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : sps_sequencer

// >>> sim/sps_sequencer_properties.sv
// property checker bound to the sequencer ports
`timescale 1ns/1ps
module sps_chk
    import sps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] ctl_in,
    input wire logic [15:0] step_outputs,
    input wire logic sequence_done_flag,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================
    // helper: cycles since any write or control reset
    logic [3:0] quiet_cnt;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // margin covers the synchroniser and run-entry latency
    always_ff @(posedge ref_clk) begin
        if (sys_rst || s_axi_wvalid || ctl_in[0]) quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hF) quiet_cnt <= quiet_cnt + 4'h1;
    end

    // ==========================================
    // properties
    property p_rst_clear;
        disable iff (1'h0) sys_rst |=> !s_axi_bvalid && !s_axi_rvalid && !sequence_done_flag && step_outputs == 16'h0000;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset left an output set");
    property p_done_hold;
        sequence_done_flag && quiet_cnt > 4'h8 |=> sequence_done_flag;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag dropped without reset");
    property p_done_freeze;
        sequence_done_flag && quiet_cnt > 4'h8 |=> $stable(step_outputs);
    endproperty
    a_done_freeze: assert property (p_done_freeze) else $error("outputs moved after completion");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response not held");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_aw_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
    property p_w_pulse;
        s_axi_wready |=> !s_axi_wready;
    endproperty
    a_w_pulse: assert property (p_w_pulse) else $error("wready longer than one cycle");
    property p_ar_to_r;
        s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ar_to_r: assert property (p_ar_to_r) else $error("read data late");
    property p_rerr_zero;
        s_axi_rvalid && s_axi_rresp == SPS_RESP_SLVERR |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_rerr_zero: assert property (p_rerr_zero) else $error("refused read returned data");
endmodule : sps_chk

bind sps_sequencer sps_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .ctl_in(ctl_in),
    .step_outputs(step_outputs), .sequence_done_flag(sequence_done_flag), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// >>> sim/sps_ctl_model.sv
// model of the controlling program driving start, jog, reset, events, scan
`timescale 1ns/1ps
module sps_ctl_model
    import sps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic start_req,
    input wire logic reset_req,
    input wire logic jog_req,
    input wire logic scan_req,
    input wire logic [15:0] event_req,
    output logic [2:0] ctl_in,
    output logic [15:0] event_in,
    output logic scan_tick
);
    sps_ctl_t ctl;
    logic [2:0] jog_cnt = 3'h0;

    // jog held four cycles high then four low so the synchroniser sees each edge
    always_ff @(posedge ref_clk) begin
        if (jog_req) jog_cnt <= 3'h7;
        else if (jog_cnt != 3'h0) jog_cnt <= jog_cnt - 3'h1;
    end

    // program levels packed in the documented bit order
    always_comb begin
        ctl.start = start_req;
        ctl.jog = jog_cnt[2];
        ctl.reset = reset_req;
    end
    assign ctl_in = ctl;

    // events and scan pulse follow the program each cycle
    always_ff @(posedge ref_clk) begin
        event_in <= event_req;
        scan_tick <= scan_req;
    end
endmodule : sps_ctl_model

// >>> sim/tb_step_pattern_sequencer.sv
// self-checking bench for the step pattern sequencer
`timescale 1ns/1ps
module tb_step_pattern_sequencer import sps_pkg::*;;
    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, scan_tick, done;
    logic [1:0] bresp, rresp;
    logic start_req = 1'h0, reset_req = 1'h0, jog_req = 1'h0, scan_req = 1'h0;
    logic [15:0] step_outputs, event_in;
    logic [15:0] ev_req = 16'hFFFF;
    logic [2:0] ctl_in;
    logic [33:0] exp_q[$];
    logic [15:0] pat[16];
    int fail_count = 0, total_checks = 0, seed = 97;

    sps_sequencer uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ctl_in(ctl_in), .event_in(event_in),
        .scan_tick(scan_tick), .step_outputs(step_outputs), .sequence_done_flag(done),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    sps_ctl_model u_prog (.ref_clk(ref_clk), .start_req(start_req), .reset_req(reset_req),
        .jog_req(jog_req), .scan_req(scan_req), .event_req(ev_req), .ctl_in(ctl_in),
        .event_in(event_in), .scan_tick(scan_tick));

    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // ==========================================
    // checking and reporting
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic give_up();
        fail_count++;
        $display("FAIL %0t wait ran out", $time);
        final_report();
    endtask : give_up
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note

    // responses come one at a time, so queue order is bus order
    always @(posedge ref_clk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            if (exp_q.size() == 0) check(34'h1, 34'h0);
            else check(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());
        end
    end

    // watchdog for the whole run
    initial begin
        repeat (100000) @(posedge ref_clk);
        give_up();
    end

    // ==========================================
    // bus master; ready raised late so held responses are exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        exp_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid && bready) break;
            if (n == 4) bready <= 1'h1;
        end
        bready <= 1'h0;
        if (n == 200) give_up();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        int n;
        exp_q.push_back(exp);
        araddr <= a;
        arvalid <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid && rready) break;
            if (n == 3) rready <= 1'h1;
        end
        rready <= 1'h0;
        if (n == 200) give_up();
    endtask : rd
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask : settle
    task automatic jog(input int n);
        repeat (n) begin
            jog_req <= 1'h1;
            @(posedge ref_clk);
            jog_req <= 1'h0;
            repeat (10) @(posedge ref_clk);
        end
    endtask : jog
    task automatic st(input int k);
        rd(SPS_ADDR_CURRENT, 34'(k));
        check({18'h0, step_outputs}, {18'h0, pat[k - 1]});
    endtask : st

    // ==========================================
    // main sequence
    initial begin
        int i, n;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        rd(SPS_ADDR_PRESET, 34'h1);
        rd(SPS_ADDR_TBASE, 34'hA);
        rd(SPS_ADDR_LAST, 34'h10);
        rd(SPS_ADDR_TIMER, 34'h0);
        rd(8'h20, {SPS_RESP_SLVERR, 32'h0});
        wr(SPS_ADDR_TICK, 32'h5, SPS_RESP_SLVERR);
        wr(SPS_ADDR_CURRENT, 32'h5, SPS_RESP_SLVERR);
        rd(SPS_ADDR_TICK, 34'h0);
        for (i = 0; i < 16; i++) begin
            pat[i] = 16'($random(seed));
            wr(8'(SPS_ADDR_PATTERN + 4 * i), {16'h0, pat[i]}, SPS_RESP_OKAY);
        end
        wr(SPS_ADDR_PRESET, 32'h3, SPS_RESP_OKAY);
        wr(SPS_ADDR_CTRL, 32'h3, SPS_RESP_OKAY);
        settle();
        st(3);
        note("run entry");
        jog(2);
        st(5);
        start_req <= 1'h1;
        jog(1);
        st(6);
        rd(SPS_ADDR_TIMER, 34'h0);
        note("jog");
        reset_req <= 1'h1;
        scan_req <= 1'h1;
        settle();
        st(3);
        reset_req <= 1'h0;
        start_req <= 1'h0;
        settle();
        st(3);
        scan_req <= 1'h0;
        note("reset and freeze");
        wr(SPS_ADDR_PRESET, 32'h14, SPS_RESP_OKAY);
        rd(SPS_ADDR_PRESET, 34'h10);
        wr(SPS_ADDR_PRESET, 32'h1, SPS_RESP_OKAY);
        reset_req <= 1'h1;
        settle();
        reset_req <= 1'h0;
        settle();
        st(1);
        jog(15);
        st(16);
        check({33'h0, done}, 34'h0);
        jog(1);
        check({33'h0, done}, 34'h1);
        st(16);
        start_req <= 1'h1;
        scan_req <= 1'h1;
        jog(1);
        st(16);
        check({33'h0, done}, 34'h1);
        note("completion");
        reset_req <= 1'h1;
        settle();
        check({33'h0, done}, 34'h0);
        st(1);
        reset_req <= 1'h0;
        for (n = 0; n < 60 && done !== 1'h1; n++) @(posedge ref_clk);
        check(34'(n >= 16 && n <= 26), 34'h1);
        st(16);
        start_req <= 1'h0;
        scan_req <= 1'h0;
        wr(SPS_ADDR_CTRL, 32'h2, SPS_RESP_OKAY);
        settle();
        check({18'h0, step_outputs}, 34'h0);
        wr(SPS_ADDR_CTRL, 32'h3, SPS_RESP_OKAY);
        settle();
        check({33'h0, done}, 34'h0);
        st(1);
        wr(SPS_ADDR_EVSEL, 32'h2, SPS_RESP_OKAY);
        ev_req <= 16'hFFFD;
        start_req <= 1'h1;
        scan_req <= 1'h1;
        settle();
        st(1);
        ev_req <= 16'hFFFF;
        repeat (40) @(posedge ref_clk);
        check({33'h0, done}, 34'h1);
        note("scan run and reentry");
        check(34'(exp_q.size()), 34'h0);
        final_report();
    end
endmodule : tb_step_pattern_sequencer
